// File: lpbk_chan_pkg.sv
/*
  Shared constants of the loopback-capable transceiver channel: reconfig_bus
  address map, control bit positions, reset values and register bank layout.
  Assumes a 10-bit byte-wide reconfiguration address space.
*/
package lpbk_chan_pkg;

  // --------------------------------------------------------------------------
  // bus geometry
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int IDX_W  = 3;
  localparam int NUM_REGS = 6;

  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REVERSE_LOOPBACK_ENABLE_CTL_OFS = 10'h11d;
  localparam logic [ADDR_W-1:0] REVERSE_PATH_SELECT_FIELD_OFS   = 10'h132;
  localparam logic [ADDR_W-1:0] PRE_RECOVERY_PATH_CTL_OFS       = 10'h137;
  localparam logic [ADDR_W-1:0] POST_RECOVERY_PATH_CTL_OFS      = 10'h13c;
  localparam logic [ADDR_W-1:0] REVERSE_BUFFER_ROUTE_CTL_OFS    = 10'h142;
  localparam logic [ADDR_W-1:0] SERIAL_LOOPBACK_CTL_OFS         = 10'h2e1;

  // --------------------------------------------------------------------------
  // bank indices
  // --------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_REV_EN   = 3'h0;
  localparam logic [IDX_W-1:0] IDX_REV_SEL  = 3'h1;
  localparam logic [IDX_W-1:0] IDX_PRE_CTL  = 3'h2;
  localparam logic [IDX_W-1:0] IDX_POST_CTL = 3'h3;
  localparam logic [IDX_W-1:0] IDX_BUF_RT   = 3'h4;
  localparam logic [IDX_W-1:0] IDX_SER_CTL  = 3'h5;

  // --------------------------------------------------------------------------
  // field positions and encodings
  // --------------------------------------------------------------------------
  localparam int REV_EN_BIT    = 0;
  localparam int REV_SEL_LSB   = 4;
  localparam int PRE_CTL_BIT   = 7;
  localparam int POST_CTL_BIT  = 7;
  localparam int BUF_RT_BIT    = 4;
  localparam int SER_LPBK_BIT  = 0;
  localparam logic [1:0] REV_SEL_PRE  = 2'h0;
  localparam logic [1:0] REV_SEL_POST = 2'h1;

  // --------------------------------------------------------------------------
  // reset values and bus answers
  // --------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_RESET_VAL = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_RDATA = 8'h00;
  localparam int DES_W_DEFAULT = 10;

  typedef enum logic [1:0] {
    OWN_CAL  = 2'b00,
    OWN_USER = 2'b01
  } owner_type;

endpackage

// File: lpbk_reg_bank.sv
/*
  Small byte-wide register bank holding the channel's loopback controls.
  Assumes one clock, synchronous active-low reset and a clock enable from
  the channel; read data come out of a register one cycle after the strobe.
*/
`timescale 1ns/1ns
module lpbk_reg_bank
  import lpbk_chan_pkg::*;
#(
  parameter int N_REGS = NUM_REGS
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic                  wr_en,
  input  wire logic [IDX_W-1:0]      wr_idx,
  input  wire logic [DATA_W-1:0]     wr_data,
  input  wire logic                  rd_en,
  input  wire logic [IDX_W-1:0]      rd_idx,
  output logic      [DATA_W-1:0]     rd_data,
  output logic      [N_REGS*DATA_W-1:0] all_regs
);
  logic [DATA_W-1:0] mem_q [N_REGS];

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_REGS; g++) begin : g_reg
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mem_q[g] <= REG_RESET_VAL;
        end else if (ce && wr_en && (wr_idx == IDX_W'(g))) begin
          mem_q[g] <= wr_data;
        end
      end
      assign all_regs[g*DATA_W +: DATA_W] = mem_q[g];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // registered read port
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= REG_RESET_VAL;
    end else if (ce && rd_en) begin
      rd_data <= mem_q[rd_idx];
    end
  end
endmodule

// File: lpbk_chan.sv
/*
  Loopback-capable transceiver channel: reconfig_bus slave with ownership
  hand-off between the user controller and the calibration_engine, the
  loopback control registers, and a bit-level serial datapath with serial,
  pre-recovery reverse and post-recovery reverse loopback.
  Assumes serializer bits arrive on CLK from channel logic; the receive pin
  is asynchronous and is synchronised here.
*/
`timescale 1ns/1ns

//Contract
//- Serial loopback feeds the serializer output into the recovery input and ignores the receive pin.
//- Driving the optional serial loopback enable port high also selects serial loopback without any access.
//- Pre-recovery reverse loopback sends the receive buffer straight to the transmit buffer; rx data still reach the deserializer.
//- Post-recovery reverse loopback sends recovered data to the transmit buffer; rx data still reach the deserializer.
module lpbk_chan
  import lpbk_chan_pkg::*;
#(
  parameter int DES_W = DES_W_DEFAULT
) (
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  input  wire logic                       CE,
  input  wire logic                       USER_BUS_REQ,
  output logic                            USER_BUS_GRANT,
  output logic                            CAL_BUS_OWNED,
  input  wire logic [lpbk_chan_pkg::ADDR_W-1:0] RECONFIG_ADDRESS,
  input  wire logic                       RECONFIG_READ,
  input  wire logic                       RECONFIG_WRITE,
  input  wire logic [lpbk_chan_pkg::DATA_W-1:0] RECONFIG_WRITEDATA,
  output logic      [lpbk_chan_pkg::DATA_W-1:0] RECONFIG_READDATA,
  output logic                            RECONFIG_READDATAVALID,
  output logic                            RECONFIG_WAITREQUEST,
  input  wire logic                       SERIAL_LPBK_EN,
  input  wire logic                       TX_SER_BIT,
  input  wire logic                       RX_PIN,
  output logic                            TX_PIN,
  output logic      [DES_W-1:0]           RX_PAR_DATA,
  output logic                            RX_PAR_VALID,
  output logic                            SERIAL_LPBK_ACTIVE,
  output logic                            PRE_REV_ACTIVE,
  output logic                            POST_REV_ACTIVE
);
  import lpbk_chan_pkg::*;

  localparam int CNT_W = $clog2(DES_W);

  owner_type                 owner_q;
  logic                      rd_pend_q;
  logic                      rd_hit_q;
  logic                      acc_ok;
  logic                      wr_hit;
  logic                      rd_hit;
  logic [IDX_W:0]            dec;
  logic [IDX_W-1:0]          wr_idx;
  logic [IDX_W-1:0]          rd_idx;
  logic [DATA_W-1:0]         bank_rdata;
  logic [NUM_REGS*DATA_W-1:0] regs;
  logic [DATA_W-1:0]         rev_en_r;
  logic [DATA_W-1:0]         rev_sel_r;
  logic [DATA_W-1:0]         pre_ctl_r;
  logic [DATA_W-1:0]         post_ctl_r;
  logic [DATA_W-1:0]         buf_rt_r;
  logic [DATA_W-1:0]         ser_ctl_r;
  logic                      rx_pin_s1_q;
  logic                      rx_pin_s2_q;
  logic                      ser_lpbk;
  logic                      pre_rev;
  logic                      post_rev;
  logic                      cdr_in;
  logic                      cdr_out_q;
  logic                      tx_pin_q;
  logic [DES_W-1:0]          shift_q;
  logic [CNT_W-1:0]          bit_cnt_q;
  logic [DES_W-1:0]          rx_par_q;
  logic                      rx_par_vld_q;

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  function automatic logic [IDX_W:0] decode(input logic [ADDR_W-1:0] a);
    logic [IDX_W:0] r;
    r = '0;
    case (a)
      REVERSE_LOOPBACK_ENABLE_CTL_OFS: r = {1'b1, IDX_REV_EN};
      REVERSE_PATH_SELECT_FIELD_OFS:   r = {1'b1, IDX_REV_SEL};
      PRE_RECOVERY_PATH_CTL_OFS:       r = {1'b1, IDX_PRE_CTL};
      POST_RECOVERY_PATH_CTL_OFS:      r = {1'b1, IDX_POST_CTL};
      REVERSE_BUFFER_ROUTE_CTL_OFS:    r = {1'b1, IDX_BUF_RT};
      SERIAL_LOOPBACK_CTL_OFS:         r = {1'b1, IDX_SER_CTL};
      default:                         r = '0;
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // bus ownership
  // --------------------------------------------------------------------------
  // user gets the bus while it requests; drop returns it to calibration
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      owner_q <= OWN_CAL;
    end else if (CE) begin
      case (owner_q)
        OWN_CAL:  owner_q <= USER_BUS_REQ ? OWN_USER : OWN_CAL;
        OWN_USER: owner_q <= USER_BUS_REQ ? OWN_USER : OWN_CAL;
        default:  owner_q <= OWN_CAL;
      endcase
    end
  end

  assign USER_BUS_GRANT = (owner_q == OWN_USER);
  assign CAL_BUS_OWNED  = (owner_q == OWN_CAL);

  // --------------------------------------------------------------------------
  // reconfig_bus slave
  // --------------------------------------------------------------------------
  // access stalls until granted; stall also covers a read already in flight
  assign acc_ok = USER_BUS_GRANT && !rd_pend_q && CE;
  assign RECONFIG_WAITREQUEST = (RECONFIG_READ || RECONFIG_WRITE) && !acc_ok;
  assign dec    = decode(RECONFIG_ADDRESS);
  assign wr_idx = dec[IDX_W-1:0];
  assign rd_idx = wr_idx;
  assign wr_hit = RECONFIG_WRITE && acc_ok && dec[IDX_W];
  assign rd_hit = RECONFIG_READ && !RECONFIG_WRITE && acc_ok;

  lpbk_reg_bank #(
    .N_REGS   (NUM_REGS)
  ) u_bank (
    .clk      (CLK),
    .rst_n    (RST_N),
    .ce       (CE),
    .wr_en    (wr_hit),
    .wr_idx   (wr_idx),
    .wr_data  (RECONFIG_WRITEDATA),
    .rd_en    (rd_hit),
    .rd_idx   (rd_idx),
    .rd_data  (bank_rdata),
    .all_regs (regs)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd_pend_q <= 1'b0;
      rd_hit_q  <= 1'b0;
    end else if (CE) begin
      rd_pend_q <= rd_hit;
      rd_hit_q  <= rd_hit && dec[IDX_W];
    end
  end

  // full byte returned so a read-modify-write keeps untouched bits
  assign RECONFIG_READDATA      = rd_hit_q ? bank_rdata : UNMAPPED_RDATA;
  assign RECONFIG_READDATAVALID = rd_pend_q && CE;

  // --------------------------------------------------------------------------
  // loopback mode decode
  // --------------------------------------------------------------------------
  assign rev_en_r   = regs[IDX_REV_EN*DATA_W +: DATA_W];
  assign rev_sel_r  = regs[IDX_REV_SEL*DATA_W +: DATA_W];
  assign pre_ctl_r  = regs[IDX_PRE_CTL*DATA_W +: DATA_W];
  assign post_ctl_r = regs[IDX_POST_CTL*DATA_W +: DATA_W];
  assign buf_rt_r   = regs[IDX_BUF_RT*DATA_W +: DATA_W];
  assign ser_ctl_r  = regs[IDX_SER_CTL*DATA_W +: DATA_W];

  assign ser_lpbk = ser_ctl_r[SER_LPBK_BIT] || SERIAL_LPBK_EN;
  assign pre_rev  = pre_ctl_r[PRE_CTL_BIT] && !post_ctl_r[POST_CTL_BIT]
                    && (rev_sel_r[REV_SEL_LSB +: 2] == REV_SEL_PRE)
                    && buf_rt_r[BUF_RT_BIT] && rev_en_r[REV_EN_BIT];
  assign post_rev = !pre_ctl_r[PRE_CTL_BIT] && post_ctl_r[POST_CTL_BIT]
                    && (rev_sel_r[REV_SEL_LSB +: 2] == REV_SEL_POST)
                    && !buf_rt_r[BUF_RT_BIT] && !rev_en_r[REV_EN_BIT];

  assign SERIAL_LPBK_ACTIVE = ser_lpbk;
  assign PRE_REV_ACTIVE     = pre_rev;
  assign POST_REV_ACTIVE    = post_rev;

  // --------------------------------------------------------------------------
  // serial datapath
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_pin_s1_q <= 1'b0;
      rx_pin_s2_q <= 1'b0;
    end else if (CE) begin
      rx_pin_s1_q <= RX_PIN;
      rx_pin_s2_q <= rx_pin_s1_q;
    end
  end

  assign cdr_in = ser_lpbk ? TX_SER_BIT : rx_pin_s2_q;

  // recovery stage modelled as one retiming flop
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cdr_out_q <= 1'b0;
    end else if (CE) begin
      cdr_out_q <= cdr_in;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tx_pin_q <= 1'b0;
    end else if (CE) begin
      if (pre_rev) begin
        tx_pin_q <= rx_pin_s2_q;
      end else if (post_rev) begin
        tx_pin_q <= cdr_out_q;
      end else begin
        tx_pin_q <= TX_SER_BIT;
      end
    end
  end

  assign TX_PIN = tx_pin_q;

  // --------------------------------------------------------------------------
  // deserializer, live in every mode
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      shift_q      <= '0;
      bit_cnt_q    <= '0;
      rx_par_q     <= '0;
      rx_par_vld_q <= 1'b0;
    end else if (CE) begin
      shift_q      <= {cdr_out_q, shift_q[DES_W-1:1]};
      rx_par_vld_q <= 1'b0;
      if (bit_cnt_q == CNT_W'(DES_W-1)) begin
        bit_cnt_q    <= '0;
        rx_par_q     <= {cdr_out_q, shift_q[DES_W-1:1]};
        rx_par_vld_q <= 1'b1;
      end else begin
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end
    end
  end

  assign RX_PAR_DATA  = rx_par_q;
  assign RX_PAR_VALID = rx_par_vld_q;
endmodule

// File: lpbk_chan_sva.sv
/* port assertions for the loopback channel: ownership, bus answers, loopback paths.
   assumes one CLK domain with synchronous active-low RST_N. */
`timescale 1ns/1ns
module lpbk_chan_sva
  import lpbk_chan_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RST_N,
  input wire logic              CE,
  input wire logic              USER_BUS_REQ,
  input wire logic              USER_BUS_GRANT,
  input wire logic              CAL_BUS_OWNED,
  input wire logic [ADDR_W-1:0] RECONFIG_ADDRESS,
  input wire logic              RECONFIG_READ,
  input wire logic              RECONFIG_WRITE,
  input wire logic [DATA_W-1:0] RECONFIG_WRITEDATA,
  input wire logic              RECONFIG_READDATAVALID,
  input wire logic              RECONFIG_WAITREQUEST,
  input wire logic              SERIAL_LPBK_EN,
  input wire logic              RX_PIN,
  input wire logic              TX_PIN,
  input wire logic              SERIAL_LPBK_ACTIVE,
  input wire logic              PRE_REV_ACTIVE,
  input wire logic              POST_REV_ACTIVE
);
  logic wr_bit;
  assign wr_bit = RECONFIG_WRITEDATA[SER_LPBK_BIT];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_grant_tracks: assert property (CE |=> USER_BUS_GRANT == $past(USER_BUS_REQ))
    else $error("grant does not follow request");
  a_cal_return: assert property (CE && !USER_BUS_REQ |=> CAL_BUS_OWNED && !USER_BUS_GRANT)
    else $error("bus not returned to calibration");
  a_refuse_ungranted: assert property ((RECONFIG_READ || RECONFIG_WRITE) && !USER_BUS_GRANT |-> RECONFIG_WAITREQUEST)
    else $error("access taken without grant");
  a_read_answer: assert property (RECONFIG_READ && !RECONFIG_WRITE && !RECONFIG_WAITREQUEST && CE
    |=> RECONFIG_READDATAVALID ##1 !RECONFIG_READDATAVALID)
    else $error("read answer not one cycle later");
  a_serial_force: assert property (SERIAL_LPBK_EN |-> SERIAL_LPBK_ACTIVE)
    else $error("enable pin does not force serial loopback");
  a_serial_write: assert property (RECONFIG_WRITE && !RECONFIG_WAITREQUEST && CE
    && RECONFIG_ADDRESS == SERIAL_LOOPBACK_CTL_OFS ##1 !SERIAL_LPBK_EN |-> SERIAL_LPBK_ACTIVE == $past(wr_bit))
    else $error("serial loopback not set by write");
  a_pre_path: assert property ((CE && PRE_REV_ACTIVE)[*4] |-> TX_PIN == $past(RX_PIN, 3))
    else $error("pre-recovery path wrong");
  a_post_path: assert property ((CE && POST_REV_ACTIVE && !SERIAL_LPBK_ACTIVE)[*5] |-> TX_PIN == $past(RX_PIN, 4))
    else $error("post-recovery path wrong");
endmodule

// File: lpbk_ctrl_model.sv
/* behavioural loopback controller doing read-modify-write on reconfig_bus.
   assumes the channel's CLK; every change lands 1 ns after a rising edge, except a write after a zero gap, at 2 ns. */
`timescale 1ns/1ns
module lpbk_ctrl_model
  import lpbk_chan_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [2:0]        sel,
  input  wire logic              start,
  input  wire logic [3:0]        gap,
  input  wire logic              grant,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic              rvalid,
  input  wire logic              waitreq,
  output logic                   req,
  output logic      [ADDR_W-1:0] addr,
  output logic                   rd,
  output logic                   wr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   busy
);
  logic [2:0]        sel_l;
  logic [DATA_W-1:0] d;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // strobe held until an edge samples waitrequest low or 64 edges have passed
  task automatic accept();
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    #1;
  endtask
  task automatic bus_rd(input logic [ADDR_W-1:0] a);
    addr = a;
    rd = 1'b1;
    accept();
    rd = 1'b0;
    addr = ~a;
    for (int i = 0; i < 8 && rvalid !== 1'b1; i++) tick(1);
    d = rdata;
    tick(1);
  endtask
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    accept();
    wr = 1'b0;
    addr = ~a;
    wdata = ~v;
  endtask
  task automatic rmw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] v);
    bus_rd(a);
    tick(gap);
    bus_wr(a, (d & ~m) | (v & m));
  endtask
  task automatic solo(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    req = 1'b1;
    for (int i = 0; i < 64 && grant !== 1'b1; i++) tick(1);
    if (w) bus_wr(a, v);
    else bus_rd(a);
    req = 1'b0;
    tick(1);
  endtask

  initial begin
    req = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    busy = 1'b0;
    addr = '0;
    wdata = '0;
    forever begin
      @(posedge clk);
      if (start === 1'b1) begin
        #1;
        sel_l = sel;
        busy = 1'b1;
        if (sel_l <= 3'b100) begin
          req = 1'b1;
          for (int i = 0; i < 64 && grant !== 1'b1; i++) tick(1);
          case (sel_l)
            3'b000: rmw(SERIAL_LOOPBACK_CTL_OFS, 8'h01, 8'h00);
            3'b001: rmw(SERIAL_LOOPBACK_CTL_OFS, 8'h01, 8'h01);
            3'b010: begin
              rmw(PRE_RECOVERY_PATH_CTL_OFS, 8'h80, 8'h80);
              rmw(POST_RECOVERY_PATH_CTL_OFS, 8'h80, 8'h00);
              rmw(REVERSE_PATH_SELECT_FIELD_OFS, 8'h30, 8'h00);
              rmw(REVERSE_BUFFER_ROUTE_CTL_OFS, 8'h10, 8'h10);
              rmw(REVERSE_LOOPBACK_ENABLE_CTL_OFS, 8'h01, 8'h01);
            end
            3'b011: begin
              rmw(PRE_RECOVERY_PATH_CTL_OFS, 8'h80, 8'h00);
              rmw(POST_RECOVERY_PATH_CTL_OFS, 8'h80, 8'h80);
              rmw(REVERSE_PATH_SELECT_FIELD_OFS, 8'h30, 8'h10);
              rmw(REVERSE_BUFFER_ROUTE_CTL_OFS, 8'h10, 8'h00);
              rmw(REVERSE_LOOPBACK_ENABLE_CTL_OFS, 8'h01, 8'h00);
            end
            default: begin
              rmw(PRE_RECOVERY_PATH_CTL_OFS, 8'h80, 8'h00);
              rmw(REVERSE_LOOPBACK_ENABLE_CTL_OFS, 8'h01, 8'h00);
              rmw(POST_RECOVERY_PATH_CTL_OFS, 8'h80, 8'h00);
            end
          endcase
          req = 1'b0;
        end
        tick(1);
        busy = 1'b0;
      end
    end
  end
endmodule

// File: tb_transceiver_loopback_reconfig_ctrl.sv
/* self-checking bench: loopback channel driven by the behavioural controller.
   assumes lpbk_chan_pkg, the design and lpbk_ctrl_model compiled first. */
`timescale 1ns/1ns
module tb_transceiver_loopback_reconfig_ctrl;
  import lpbk_chan_pkg::*;
  localparam int DW = 10;
  logic          clk = 0, rst_n = 0, ser_en = 0, tx_bit = 0, rx_pin = 0, start = 0, hold = 0;
  logic          probe = 0, watch = 0, busy_q = 0;
  logic [2:0]    sel = 0, m = 0;
  logic [3:0]    gap = 0;
  logic [7:0]    v;
  logic [31:0]   rnd = 32'h3390_43b9;
  logic          req, grant, cal, rd, wr, rvalid, waitreq, tx_pin, rx_valid, s_act, p_act, q_act, busy;
  logic [9:0]    addr;
  logic [7:0]    wdata, rdata;
  logic [DW-1:0] rx_par;
  logic [2:0]    exp_mode[$];
  logic [7:0]    exp_byte[$];
  logic [DW-1:0] exp_word[$];
  logic          exp_tx[$];
  logic [9:0]    ofs[7] = '{10'h11d, 10'h132, 10'h137, 10'h13c, 10'h142, 10'h2e1, 10'h3ff};
  int            bad_count = 0, total_checks = 0;

  always #20 clk = ~clk;

  lpbk_chan #(.DES_W(DW)) i_dut (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .USER_BUS_REQ(req), .USER_BUS_GRANT(grant),
    .CAL_BUS_OWNED(cal), .RECONFIG_ADDRESS(addr), .RECONFIG_READ(rd), .RECONFIG_WRITE(wr), .RECONFIG_WRITEDATA(wdata),
    .RECONFIG_READDATA(rdata), .RECONFIG_READDATAVALID(rvalid), .RECONFIG_WAITREQUEST(waitreq),
    .SERIAL_LPBK_EN(ser_en), .TX_SER_BIT(tx_bit), .RX_PIN(rx_pin), .TX_PIN(tx_pin), .RX_PAR_DATA(rx_par),
    .RX_PAR_VALID(rx_valid), .SERIAL_LPBK_ACTIVE(s_act), .PRE_REV_ACTIVE(p_act), .POST_REV_ACTIVE(q_act));
  lpbk_ctrl_model i_ctrl (.clk(clk), .sel(sel), .start(start), .gap(gap), .grant(grant), .rdata(rdata),
    .rvalid(rvalid), .waitreq(waitreq), .req(req), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .busy(busy));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (e !== g) begin
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      bad_count++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
    rnd = lfsr(rnd);
    if (!hold) begin
      tx_bit = rnd[0];
      rx_pin = rnd[7];
    end
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    exp_byte.push_back(e);
    probe = 1'b1;
    i_ctrl.solo(1'b0, a, 8'h00);
    probe = 1'b0;
  endtask
  task automatic chk_rx(input logic t, input logic r, input logic [DW-1:0] e);
    hold = 1'b1;
    tx_bit = t;
    rx_pin = r;
    repeat (3 * DW) step();
    exp_word.push_back(e);
    exp_tx.push_back((m[1] | m[0]) ? r : t);
    watch = 1'b1;
    repeat (DW + 1) step();
    watch = 1'b0;
    hold = 1'b0;
  endtask
  task automatic op(input logic [2:0] c);
    case (c)
      3'b000: m[2] = 1'b0;
      3'b001: m[2] = 1'b1;
      3'b010: m[1:0] = 2'b10;
      3'b011: m[1:0] = 2'b01;
      3'b100: m[1:0] = 2'b00;
      default: ;
    endcase
    exp_mode.push_back(m);
    sel = c;
    gap = rnd[11:8];
    start = 1'b1;
    step();
    start = 1'b0;
    step();
    sel = rnd[2:0];
    for (int i = 0; i < 500 && busy !== 1'b0; i++) step();
    repeat (8) step();
    $display("test mode %b done", c);
  endtask

  // --------------------------------------------------------------------------
  // result watcher
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    busy_q <= busy;
    if (busy_q === 1'b1 && busy === 1'b0 && exp_mode.size() > 0) check("mode", exp_mode.pop_front(), {s_act, p_act, q_act});
    if (probe && rvalid === 1'b1 && exp_byte.size() > 0) check("readback", exp_byte.pop_front(), rdata);
    if (watch && rx_valid === 1'b1 && exp_word.size() > 0) check("rx word", exp_word.pop_front(), rx_par);
    if (watch && rx_valid === 1'b1 && exp_tx.size() > 0) check("tx pin", exp_tx.pop_front(), tx_pin);
    if (busy_q === 1'b1 && busy === 1'b0) check("bus owner", 16'h0001, cal);
  end

  initial begin
    #(40 * 20000);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step();
    i_ctrl.solo(1'b1, 10'h3ff, 8'hff);
    for (int i = 0; i < 7; i++) rd_chk(ofs[i], 8'h00);
    $display("test reset values done");
    v = rnd[23:16] & 8'hfe;
    i_ctrl.solo(1'b1, 10'h2e1, v);
    op(3'b001);
    rd_chk(10'h2e1, v | 8'h01);
    chk_rx(1'b1, 1'b0, '1);
    op(3'b000);
    rd_chk(10'h2e1, v);
    chk_rx(1'b1, 1'b0, '0);
    ser_en = 1'b1;
    chk_rx(1'b1, 1'b0, '1);
    ser_en = 1'b0;
    v = rnd[31:24] & 8'hef;
    i_ctrl.solo(1'b1, 10'h142, v);
    op(3'b010);
    rd_chk(10'h142, v | 8'h10);
    chk_rx(1'b0, 1'b1, '1);
    op(3'b100);
    op(3'b011);
    chk_rx(1'b0, 1'b1, '1);
    op(3'b100);
    for (int c = 5; c < 8; c++) op(c[2:0]);
    tally_and_finish();
  end
endmodule

bind lpbk_chan lpbk_chan_sva i_sva (.CLK(CLK), .RST_N(RST_N), .CE(CE), .USER_BUS_REQ(USER_BUS_REQ),
  .USER_BUS_GRANT(USER_BUS_GRANT), .CAL_BUS_OWNED(CAL_BUS_OWNED), .RECONFIG_ADDRESS(RECONFIG_ADDRESS),
  .RECONFIG_READ(RECONFIG_READ), .RECONFIG_WRITE(RECONFIG_WRITE), .RECONFIG_WRITEDATA(RECONFIG_WRITEDATA),
  .RECONFIG_READDATAVALID(RECONFIG_READDATAVALID), .RECONFIG_WAITREQUEST(RECONFIG_WAITREQUEST),
  .SERIAL_LPBK_EN(SERIAL_LPBK_EN), .RX_PIN(RX_PIN), .TX_PIN(TX_PIN), .SERIAL_LPBK_ACTIVE(SERIAL_LPBK_ACTIVE),
  .PRE_REV_ACTIVE(PRE_REV_ACTIVE), .POST_REV_ACTIVE(POST_REV_ACTIVE));
